// >>> hw/asop_pkg.sv
// constants, field positions and types of the serial and parallel result output port
package asop_pkg;
  localparam int unsigned WORD_W      = 16;
  localparam int unsigned FIFO_DEPTH  = 8;
  localparam int unsigned CNT_W       = 5;
  localparam logic [4:0]  BITS_LAST   = 5'h0f;
  localparam logic [4:0]  BITS_ALL    = 5'h10;
  localparam int unsigned PAR_BIT_FIVE = 5;
  // synchronised configuration vector positions
  localparam int unsigned CFG_W    = 6;
  localparam int unsigned CFG_SER  = 0;
  localparam int unsigned CFG_EXT  = 1;
  localparam int unsigned CFG_FMT  = 2;
  localparam int unsigned CFG_SYNC = 3;
  localparam int unsigned CFG_INV  = 4;
  localparam int unsigned CFG_RDC  = 5;
  // synchronised link pin positions
  localparam int unsigned PIN_W   = 3;
  localparam int unsigned PIN_CLK = 0;
  localparam int unsigned PIN_CS  = 1;
  localparam int unsigned PIN_DIN = 2;
  // master clock: one bit per period, data moves at count zero
  localparam int unsigned DIV_W    = 3;
  localparam logic [2:0]  DIV_RISE = 3'h2;
  localparam logic [2:0]  DIV_FALL = 3'h6;
  localparam logic [2:0]  DIV_LAST = 3'h7;
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [15:0] MSB_MASK = 16'h8000;

  typedef enum logic {ASOP_IDLE, ASOP_SHIFT} asop_state_t;
endpackage : asop_pkg

// >>> hw/asop_fifo.sv
// result word fifo with valid/ready on both sides
`timescale 1ns/1ps
module asop_fifo #(
  parameter int unsigned W     = 16,
  parameter int unsigned DEPTH = 8
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  // fill side
  input  wire logic         in_valid_i,
  input  wire logic [W-1:0] in_data_i,
  output logic              in_ready_o,
  // drain side
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  localparam int unsigned PW = $clog2(DEPTH);
  localparam int unsigned CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0]           wp;
    logic [PW-1:0]           rp;
    logic [CW-1:0]           cnt;
    logic                    full;
    logic                    empty;
  } asop_fifo_t;

  asop_fifo_t r;
  asop_fifo_t next_r;
  logic       push;
  logic       pop;

  always_comb begin
    next_r = r;
    push   = in_valid_i && !r.full;
    pop    = out_ready_i && !r.empty;
    if (push) begin
      next_r.mem[r.wp] = in_data_i;
      next_r.wp        = PW'((r.wp + 1'b1) % DEPTH);
    end
    if (pop) begin
      next_r.rp = PW'((r.rp + 1'b1) % DEPTH);
    end
    if (push && !pop) begin
      next_r.cnt = r.cnt + 1'b1;
    end else if (pop && !push) begin
      next_r.cnt = r.cnt - 1'b1;
    end
    next_r.full  = (next_r.cnt == CNT_FULL);
    next_r.empty = (next_r.cnt == '0);
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r       <= '0;
      r.empty <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign in_ready_o  = !r.full;
  assign out_valid_o = !r.empty;
  assign out_data_o  = r.mem[r.rp];
endmodule : asop_fifo

// >>> hw/asop_port.sv
// serial and parallel result output port
`timescale 1ns/1ps
module asop_port
  import asop_pkg::*;
(
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  // conversion side
  input  wire logic [WORD_W-1:0] result_i,
  input  wire logic              result_valid_i,
  input  wire logic              conv_busy_i,
  output logic                   result_ready_o,
  // configuration pins
  input  wire logic              serial_parallel_sel_i,
  input  wire logic              clock_source_sel_i,
  input  wire logic              output_format_sel_i,
  input  wire logic              frame_sync_polarity_sel_i,
  input  wire logic              clock_edge_invert_sel_i,
  input  wire logic              read_during_convert_sel_i,
  // serial link
  input  wire logic              serial_result_clock_i,
  input  wire logic              chip_select_n_i,
  input  wire logic              daisy_chain_in_i,
  output logic                   serial_result_clock_o,
  output logic                   serial_result_clock_oe_o,
  output logic                   serial_result_out_o,
  output logic                   frame_sync_o,
  // parallel bus
  output logic [WORD_W-1:0]      par_data_o,
  output logic                   par_data_oe_o
);
  typedef struct packed {
    asop_state_t       st;
    logic [CFG_W-1:0]  cfg1;
    logic [CFG_W-1:0]  cfg2;
    logic [PIN_W-1:0]  pin1;
    logic [PIN_W-1:0]  pin2;
    logic [PIN_W-1:0]  pin3;
    logic [WORD_W-1:0] sh;
    logic [CNT_W-1:0]  cnt;
    logic [DIV_W-1:0]  div;
    logic              sclk;
    logic              sync;
    logic              sdo;
    logic [WORD_W-1:0] par;
    logic              par_oe;
    logic              sclk_oe;
    logic              sclk_pin;
    logic              sync_pin;
    logic              rdy;
  } asop_port_t;

  asop_port_t        r;
  asop_port_t        next_r;
  logic              pop;
  logic              f_valid;
  logic              f_ready;
  logic [WORD_W-1:0] f_data;
  logic [WORD_W-1:0] word;
  logic              ser;
  logic              slave;
  logic              inv;
  logic              act_edge;
  logic              cs_act;
  logic              cs_start;

  asop_fifo #(
    .W     (WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (result_valid_i),
    .in_data_i   (result_i),
    .in_ready_o  (f_ready),
    .out_valid_o (f_valid),
    .out_ready_i (pop),
    .out_data_o  (f_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    next_r   = r;
    pop      = 1'b0;
    ser      = r.cfg2[CFG_SER];
    slave    = r.cfg2[CFG_EXT];
    inv      = r.cfg2[CFG_INV];
    word     = f_data ^ (output_format_mask(r.cfg2[CFG_FMT]));
    // edge select on the synchronised external clock
    act_edge = inv ? (!r.pin2[PIN_CLK] && r.pin3[PIN_CLK])
                   : (r.pin2[PIN_CLK] && !r.pin3[PIN_CLK]);
    cs_act   = !r.pin2[PIN_CS];
    cs_start = cs_act && r.pin3[PIN_CS];
    next_r.cfg1 = {read_during_convert_sel_i, clock_edge_invert_sel_i,
                   frame_sync_polarity_sel_i, output_format_sel_i,
                   clock_source_sel_i, serial_parallel_sel_i};
    next_r.cfg2 = r.cfg1;
    next_r.pin1 = {daisy_chain_in_i, chip_select_n_i, serial_result_clock_i};
    next_r.pin2 = r.pin1;
    next_r.pin3 = r.pin2;
    next_r.par_oe  = !ser;
    next_r.sclk_oe = ser && !slave;
    case (r.st)
      ASOP_IDLE: begin
        next_r.sclk = 1'b0;
        next_r.sync = 1'b0;
        next_r.sdo  = 1'b0;
        next_r.cnt  = '0;
        next_r.div  = '0;
        if (!ser) begin
          if (f_valid) begin
            pop        = 1'b1;
            next_r.par = word;
          end
        end else if (!slave) begin
          // read mode choice of the master
          if (f_valid && (r.cfg2[CFG_RDC] ? conv_busy_i : !conv_busy_i)) begin
            pop        = 1'b1;
            next_r.sh  = word;
            next_r.sdo = word[WORD_W-1];
            next_r.sync = 1'b1;
            next_r.st  = ASOP_SHIFT;
          end
        end else if (cs_start) begin
          pop        = f_valid;
          next_r.sh  = f_valid ? word : WORD_RST;
          next_r.sdo = f_valid ? word[WORD_W-1] : 1'b0;
          next_r.st  = ASOP_SHIFT;
        end
      end
      ASOP_SHIFT: begin
        if (!slave) begin
          next_r.div  = r.div + 1'b1;
          next_r.sclk = (r.div == DIV_RISE - 1'b1) ? 1'b1 :
                        (r.div == DIV_FALL - 1'b1) ? 1'b0 : r.sclk;
          // data moves mid-low, away from both edges
          if (r.div == DIV_LAST) begin
            if (r.cnt == BITS_LAST) begin
              next_r.st   = ASOP_IDLE;
              next_r.sync = 1'b0;
              next_r.sdo  = 1'b0;
            end else begin
              next_r.cnt = r.cnt + 1'b1;
              next_r.sh  = {r.sh[WORD_W-2:0], 1'b0};
              next_r.sdo = r.sh[WORD_W-2];
            end
          end
        end else if (!cs_act || !ser) begin
          next_r.st = ASOP_IDLE;
        end else if (act_edge) begin
          // chain input enters behind the result word
          next_r.sh  = {r.sh[WORD_W-2:0], r.pin2[PIN_DIN]};
          next_r.sdo = r.sh[WORD_W-2];
          if (r.cnt != BITS_ALL) begin
            next_r.cnt = r.cnt + 1'b1;
          end
        end
      end
      default: begin
        next_r.st = ASOP_IDLE;
      end
    endcase
    // pin levels registered after polarity and edge select
    next_r.sync_pin = next_r.sync ^ next_r.cfg2[CFG_SYNC];
    next_r.sclk_pin = next_r.sclk ^ next_r.cfg2[CFG_INV];
    next_r.rdy      = f_ready;
  end

  function automatic logic [WORD_W-1:0] output_format_mask(input logic fmt);
    output_format_mask = fmt ? WORD_RST : MSB_MASK;
  endfunction : output_format_mask

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r      <= '0;
      r.pin1 <= '1;
      r.pin2 <= '1;
      r.pin3 <= '1;
    end else begin
      r <= next_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign result_ready_o           = r.rdy;
  assign serial_result_clock_o    = r.sclk_pin;
  assign serial_result_clock_oe_o = r.sclk_oe;
  assign serial_result_out_o      = r.sdo;
  assign frame_sync_o             = r.sync_pin;
  assign par_data_o               = r.par;
  assign par_data_oe_o            = r.par_oe;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_master_start;
    r.st == ASOP_IDLE && r.cfg2[CFG_SER] && !r.cfg2[CFG_EXT] && pop;
  endsequence

  sequence s_shift_run;
    r.st == ASOP_SHIFT && !r.cfg2[CFG_EXT];
  endsequence

  AST_PAR_BIT_FIVE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (r.st == ASOP_IDLE && !r.cfg2[CFG_SER] && pop)
      |=> par_data_o[PAR_BIT_FIVE] == $past(word[PAR_BIT_FIVE]))
    else $error("parallel bit five not driven from result");

  AST_SYNC_POLARITY: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_shift_run ##1 (s_shift_run and $stable(r.cfg2[CFG_SYNC]))
      |-> frame_sync_o == !r.cfg2[CFG_SYNC])
    else $error("frame sync polarity wrong");

  AST_RDC_LOW: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (s_master_start and (!r.cfg2[CFG_RDC])) |-> !conv_busy_i)
    else $error("read after convert started during conversion");

  AST_RDC_HIGH: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (s_master_start and r.cfg2[CFG_RDC]) |-> conv_busy_i)
    else $error("read during convert started while idle");

  AST_MSB_FIRST: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_master_start |=> serial_result_out_o == $past(word[WORD_W-1])
      && frame_sync_o != r.cfg2[CFG_SYNC])
    else $error("first bit is not msb or sync not active");

  AST_FORMAT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (pop && r.cfg2[CFG_SER]) |-> word[WORD_W-1] == (f_data[WORD_W-1] ^ !r.cfg2[CFG_FMT]))
    else $error("format msb inversion wrong");

  AST_MASTER_STABLE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (s_shift_run and $changed(r.sclk)) |-> $stable(serial_result_out_o))
    else $error("master data moved on a clock edge");

  AST_SLAVE_EDGE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (r.st == ASOP_SHIFT && $past(r.st) == ASOP_SHIFT && r.cfg2[CFG_EXT] && $changed(r.sh))
      |-> $past(act_edge))
    else $error("slave data moved without active edge");

  AST_SIXTEEN_BITS: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (s_shift_run ##1 (r.st == ASOP_IDLE)) |-> $past(r.cnt) == BITS_LAST)
    else $error("master frame not sixteen bits");
endmodule : asop_port

// >>> test/asop_host.sv
// host serial port model: gated slave clock, chip select and chain data
`timescale 1ns/1ps
module asop_host (
  // link toward the port
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      din_o,
  input  wire logic sdo_i
);
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    din_o  = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // one frame of 32 active edges; bits seen and chain bits sent
  task automatic frame(input logic edge_inv, inout int seed,
                       output logic [31:0] seen, output logic [15:0] sent);
    #3;
    sclk_o = edge_inv;                 // idle level before the frame
    #40 cs_n_o = 1'b0;                 // clock only while selected
    #80;
    for (int k = 0; k < 32; k++) begin
      #20;
      seen[31-k] = sdo_i;
      din_o      = 1'($random(seed));
      if (k < 16) sent[15-k] = din_o;
      #20 sclk_o = ~edge_inv;          // active edge
      #40 sclk_o = edge_inv;
    end
    #40 cs_n_o = 1'b1;
    din_o = ~din_o;
  endtask : frame
endmodule : asop_host

// >>> test/testbench.sv
// self-checking bench of the serial and parallel result output port
`timescale 1ns/1ps
module testbench;
  import asop_pkg::*;
  logic              clk_i          = 1'b0;
  logic              rst_n_i        = 1'b0;
  logic [WORD_W-1:0] result_i       = '0;
  logic              result_valid_i = 1'b0;
  logic              conv_busy_i    = 1'b0;
  logic              ser = 1'b0, ext = 1'b0, fmt = 1'b1, pol = 1'b0, inv = 1'b0, read_during_convert_sel = 1'b0;
  logic              rdy, sclk_o, sclk_oe, sdo, fsync, par_oe, h_clk, h_cs_n, h_din;
  logic [WORD_W-1:0] par;
  int                n_mismatch   = 0;
  int                total_checks = 0;
  int                seed         = 49;
  int                q[$];

  always #4 clk_i = ~clk_i;

  asop_port dut_u (
    .clk_i                     (clk_i),
    .rst_n_i                   (rst_n_i),
    .result_i                  (result_i),
    .result_valid_i            (result_valid_i),
    .conv_busy_i               (conv_busy_i),
    .result_ready_o            (rdy),
    .serial_parallel_sel_i     (ser),
    .clock_source_sel_i        (ext),
    .output_format_sel_i       (fmt),
    .frame_sync_polarity_sel_i (pol),
    .clock_edge_invert_sel_i   (inv),
    .read_during_convert_sel_i (read_during_convert_sel),
    .serial_result_clock_i     (h_clk),
    .chip_select_n_i           (h_cs_n),
    .daisy_chain_in_i          (h_din),
    .serial_result_clock_o     (sclk_o),
    .serial_result_clock_oe_o  (sclk_oe),
    .serial_result_out_o       (sdo),
    .frame_sync_o              (fsync),
    .par_data_o                (par),
    .par_data_oe_o             (par_oe)
  );
  asop_host host_u (.sclk_o(h_clk), .cs_n_o(h_cs_n), .din_o(h_din), .sdo_i(sdo));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : conclude
  function automatic logic [15:0] fw(input int w, input logic f);
    return f ? w[15:0] : (w[15:0] ^ 16'h8000);  // msb inverted when low
  endfunction : fw
  task automatic push(input int n);
    repeat (n) begin
      @(negedge clk_i);
      result_i       = 16'($random(seed));
      result_valid_i = 1'b1;
      q.push_back(result_i);
    end
    @(negedge clk_i) result_valid_i = 1'b0;
  endtask : push
  // order {rdc, inv, pol, fmt, ext, ser}
  task automatic cfg(input logic [5:0] c);
    {read_during_convert_sel, inv, pol, fmt, ext, ser} = c;
    repeat (6) @(negedge clk_i);
  endtask : cfg
  task automatic wait_clk(input logic lvl);
    int t;
    t = 0;
    while ((sclk_o ^ inv) !== lvl && t < 40) begin
      @(negedge clk_i);
      t++;
    end
    check("clock edge wait", t < 40, 1'b1);
  endtask : wait_clk
  task automatic master_frame(input logic [15:0] exp);
    logic [15:0] got;
    int          t;
    t = 0;
    while ((fsync ^ pol) !== 1'b1 && t < 300) begin
      @(negedge clk_i);
      t++;
    end
    check("frame start wait", t < 300, 1'b1);
    for (int b = 15; b >= 0; b--) begin
      wait_clk(1'b1);
      got[b] = sdo;
      check("sync held", fsync ^ pol, 1'b1);
      wait_clk(1'b0);
      check("bit on both edges", sdo, got[b]);
    end
    check("master word", got, exp);
    repeat (12) @(negedge clk_i);
    check("sync after frame", fsync ^ pol, 1'b0);
  endtask : master_frame

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] seen;
    logic [15:0] sent;
    logic [15:0] e;
    repeat (20) @(negedge clk_i);
    rst_n_i = 1'b1;
    repeat (3) @(negedge clk_i);
    // parallel words, both formats
    for (int i = 0; i < 4; i++) begin
      cfg({3'h0, i[0], 2'h0});
      push(1);
      repeat (4) @(negedge clk_i);
      e = fw(q.pop_front(), i[0]);
      check("parallel word", par, e);
      check("parallel bit five", par[PAR_BIT_FIVE], e[PAR_BIT_FIVE]);
      check("parallel enable", par_oe, 1'b1);
    end
    // master frames over read mode, polarity, edge and format
    for (int i = 0; i < 8; i++) begin
      conv_busy_i = ~i[1];
      cfg({i[1], i[2], i[0] ^ i[2], i[0], 2'h1});
      push(1);
      repeat (30) @(negedge clk_i);
      check("no frame on wrong busy", fsync ^ pol, 1'b0);
      check("master clock enable", sclk_oe, 1'b1);
      check("parallel enable off", par_oe, 1'b0);
      conv_busy_i = i[1];
      master_frame(fw(q.pop_front(), i[0]));
    end
    // slave: fill the fifo, then drain it frame by frame
    cfg(6'h07);
    push(8);
    repeat (2) @(negedge clk_i);
    check("fifo full", rdy, 1'b0);
    for (int i = 0; i < 9; i++) begin
      cfg({1'b0, i[0], 1'b0, i[1] | i[3], 2'h3});
      host_u.frame(i[0], seed, seen, sent);
      e = (i < 8) ? fw(q.pop_front(), i[1]) : 16'h0000;
      check("slave word", seen[31:16], e);
      check("chain pass", seen[15:0], sent);
      check("slave clock enable", sclk_oe, 1'b0);
    end
    check("fifo drained", rdy, 1'b1);
    conclude();
  end

  initial begin
    #400000;
    n_mismatch++;
    conclude();
  end
endmodule : testbench
